// file: hdl/ela_consts.vh
`ifndef ELA_CONSTS_VH
`define ELA_CONSTS_VH
// register byte offsets
`define ELA_OFS_CTRL      12'h000
`define ELA_OFS_STATUS    12'h004
`define ELA_OFS_ISTAT     12'h008
`define ELA_OFS_IMASK     12'h00C
`define ELA_OFS_MODE      12'h010
`define ELA_OFS_DEPTH     12'h014
`define ELA_OFS_REQ       12'h018
`define ELA_OFS_RDIDX     12'h01C
`define ELA_STG_BASE      12'h040
`define ELA_STG_END       12'h09F
`define ELA_STG_SHIFT     5
`define ELA_FLD_CARE_LO   5'h00
`define ELA_FLD_CARE_HI   5'h04
`define ELA_FLD_EDGE_LO   5'h08
`define ELA_FLD_EDGE_HI   5'h0C
`define ELA_FLD_VAL_LO    5'h10
`define ELA_FLD_VAL_HI    5'h14
`define ELA_RDAT_BASE     12'h200
`define ELA_RDAT_END      12'h3FF
`define ELA_STIM_BASE     12'h400
`define ELA_STIM_END      12'h43F
// control register fields
`define ELA_CTRL_ARM      0
`define ELA_CTRL_ABORT    1
`define ELA_CTRL_PRE_LO   4
`define ELA_CTRL_PRE_HI   5
`define ELA_CTRL_NTRG_LO  8
`define ELA_CTRL_NTRG_HI  9
// interrupt status bits
`define ELA_INT_TRIG      0
`define ELA_INT_DONE      1
`define ELA_INT_W         2
// decode regions
`define ELA_RGN_BAD       3'h0
`define ELA_RGN_REG       3'h1
`define ELA_RGN_STG       3'h2
`define ELA_RGN_STIM      3'h3
`define ELA_RGN_RDAT      3'h4
// bus answers
`define ELA_RESP_OKAY     2'h0
`define ELA_RESP_SLVERR   2'h2
`define ELA_STIM_MAX      512
`define ELA_NSTG          3
`endif

// file: hdl/ela_trig_match.v
`default_nettype none
module ela_trig_match #(
  parameter W = 8
) (
  input  wire [W-1:0] i_care,
  input  wire [W-1:0] i_edge,
  input  wire [W-1:0] i_val,
  input  wire [W-1:0] i_cur,
  input  wire [W-1:0] i_prev,
  input  wire         i_and_mode,
  output wire         o_match
);
  wire [W-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_ch
      // edge: val 1 rising, val 0 falling; level compares value only
      assign hit[g] = i_edge[g] ? ((i_cur[g] == i_val[g]) && (i_prev[g] != i_val[g]))
                                : (i_cur[g] == i_val[g]);
    end
  endgenerate
  wire all_ok = &(hit | ~i_care);
  wire any_ok = |(hit & i_care);
  // an all don't-care stage matches at once in either mode
  assign o_match = i_and_mode ? all_ok : (any_ok | ~|i_care);
endmodule // ela_trig_match
`default_nettype wire

// file: hdl/ela_trace_mem.v
`default_nettype none
module ela_trace_mem #(
  parameter W     = 8,
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  input  wire          i_core_clk,
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [W-1:0]  i_wdata,
  input  wire [AW-1:0] i_raddr,
  output wire [W-1:0]  o_rdata
);
  reg [W-1:0] mem_ff [0:DEPTH-1];
  // no reset: contents are only meaningful after a finished capture
  always @(posedge i_core_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end
  assign o_rdata = mem_ff[i_raddr];
endmodule // ela_trace_mem
`default_nettype wire

// file: hdl/ela_core.v
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "ela_consts.vh"
`default_nettype none
module ela_core #(
  parameter MON_W   = 38,
  parameter DEPTH   = 1024,
  parameter AW      = 10,
  parameter TRIG_W  = 8,
  parameter STIM_W  = 9,
  parameter STIM_OW = (STIM_W > 0) ? STIM_W : 1
) (
  input  wire               i_core_clk,
  input  wire               i_rstn,
  input  wire [MON_W-1:0]   i_monitor,
  input  wire [TRIG_W-1:0]  i_trigger,
  output reg  [STIM_OW-1:0] o_stimuli,
  output reg                o_stimuli_valid,
  output reg                o_irq,
  input  wire [11:0]        i_awaddr,
  input  wire               i_awvalid,
  output reg                o_awready,
  input  wire [31:0]        i_wdata,
  input  wire [3:0]         i_wstrb,
  input  wire               i_wvalid,
  output reg                o_wready,
  output reg  [1:0]         o_bresp,
  output reg                o_bvalid,
  input  wire               i_bready,
  input  wire [11:0]        i_araddr,
  input  wire               i_arvalid,
  output reg                o_arready,
  output reg  [31:0]        o_rdata,
  output reg  [1:0]         o_rresp,
  output reg                o_rvalid,
  input  wire               i_rready
);
  localparam SW     = MON_W + 1;
  localparam NMW    = (SW + 31) / 32;
  localparam NSTW   = (STIM_OW + 31) / 32;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FILL = 2'h1;
  localparam [1:0] ST_TRIG = 2'h2;
  localparam [1:0] ST_POST = 2'h3;
  localparam [AW:0] DEPTH_N = DEPTH[AW:0];
  localparam [AW:0] QUART_N = DEPTH_N >> 2;

  function [2:0] rgn;
    input [11:0] a;
    begin
      if (a <= `ELA_OFS_RDIDX)
        rgn = `ELA_RGN_REG;
      else if (a >= `ELA_STG_BASE && a <= `ELA_STG_END && a[4:0] <= `ELA_FLD_VAL_HI)
        rgn = `ELA_RGN_STG;
      else if (a >= `ELA_RDAT_BASE && a <= `ELA_RDAT_END && a[8:2] < NMW)
        rgn = `ELA_RGN_RDAT;
      else if (a >= `ELA_STIM_BASE && a <= `ELA_STIM_END && a[5:2] < NSTW && STIM_W > 0)
        rgn = `ELA_RGN_STIM;
      else
        rgn = `ELA_RGN_BAD;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) merge[8*k +: 8] = nw[8*k +: 8];
      end
    end
  endfunction

  // register state
  reg [1:0]          pre_ff;
  reg [1:0]          ntrg_ff;
  reg [2:0]          and_ff;
  reg [`ELA_INT_W-1:0] istat_ff;
  reg [`ELA_INT_W-1:0] imask_ff;
  reg [31:0]         req_ff;
  reg [AW-1:0]       rdidx_ff;
  reg [63:0]         care_ff [0:`ELA_NSTG-1];
  reg [63:0]         edge_ff [0:`ELA_NSTG-1];
  reg [63:0]         val_ff  [0:`ELA_NSTG-1];
  reg [STIM_OW-1:0]  stim_ff;
  reg                arm_ff;
  reg                abort_ff;
  // capture state
  reg [1:0]          st_ff;
  reg [1:0]          stg_ff;
  reg [AW-1:0]       wptr_ff;
  reg [AW-1:0]       start_ff;
  reg [AW:0]         cnt_ff;
  reg                done_ff;
  reg [TRIG_W-1:0]   prev_ff;
  reg                ev_trig_ff;
  reg                ev_done_ff;
  // bus state
  reg                aw_full_ff;
  reg                w_full_ff;
  reg [11:0]         aw_addr_ff;
  reg [31:0]         w_data_ff;
  reg [3:0]          w_strb_ff;

  wire [AW:0]        pre_n  = QUART_N * {{(AW-1){1'b0}}, pre_ff};
  wire [AW:0]        post_n = DEPTH_N - pre_n;
  wire [1:0]         last_stg = (ntrg_ff == 2'h0) ? 2'h0 : ntrg_ff - 2'h1;
  wire               wr_go   = aw_full_ff && w_full_ff && !o_bvalid;
  wire [2:0]         wr_rgn  = rgn(aw_addr_ff);
  wire [1:0]         wr_stg  = aw_addr_ff[6:5] - 2'h2;
  wire               rd_go   = i_arvalid && o_arready;
  wire [2:0]         rd_rgn  = rgn(i_araddr);
  wire [1:0]         rd_stg  = i_araddr[6:5] - 2'h2;
  wire               warn    = (req_ff != DEPTH) && (req_ff != 32'h0);

  // one matcher per stage so each keeps its own AND/OR choice
  wire [`ELA_NSTG-1:0] stg_hit;
  genvar g;
  generate
    for (g = 0; g < `ELA_NSTG; g = g + 1) begin : g_stg
      ela_trig_match #(.W(TRIG_W)) u_match (
        .i_care     (care_ff[g][TRIG_W-1:0]),
        .i_edge     (edge_ff[g][TRIG_W-1:0]),
        .i_val      (val_ff[g][TRIG_W-1:0]),
        .i_cur      (i_trigger),
        .i_prev     (prev_ff),
        .i_and_mode (and_ff[g]),
        .o_match    (stg_hit[g])
      );
    end
  endgenerate
  wire cur_hit = stg_hit[stg_ff];

  // trace storage: monitor word plus pre-store marker
  reg              mem_we;
  reg              marker;
  wire [SW-1:0]    mem_rd;
  wire [NMW*32-1:0] rd_pad = {{(NMW*32-SW){1'b0}}, mem_rd};
  ela_trace_mem #(.W(SW), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (mem_we),
    .i_waddr    (wptr_ff),
    .i_wdata    ({marker, i_monitor}),
    .i_raddr    (start_ff + rdidx_ff),
    .o_rdata    (mem_rd)
  );

  // capture sequencer
  reg [1:0]  nxt_st;
  reg [1:0]  nxt_stg;
  reg [AW:0] nxt_cnt;
  reg        nxt_done;
  reg        nxt_ev_trig;
  reg        nxt_ev_done;
  always @* begin
    nxt_st      = st_ff;
    nxt_stg     = stg_ff;
    nxt_cnt     = cnt_ff;
    nxt_done    = done_ff;
    nxt_ev_trig = 1'b0;
    nxt_ev_done = 1'b0;
    mem_we      = 1'b0;
    marker      = 1'b1;
    case (st_ff)
      ST_IDLE: begin
        if (arm_ff) begin
          nxt_done = 1'b0;
          nxt_stg  = 2'h0;
          nxt_cnt  = {(AW+1){1'b0}};
          nxt_st   = (pre_n == {(AW+1){1'b0}}) ? ST_TRIG : ST_FILL;
        end
      end
      ST_FILL: begin
        mem_we  = 1'b1;
        nxt_cnt = cnt_ff + 1'b1;
        if (nxt_cnt == pre_n) begin
          nxt_st = ST_TRIG;
        end
      end
      ST_TRIG: begin
        mem_we = 1'b1;
        if (cur_hit) begin
          if (stg_ff == last_stg) begin
            marker      = 1'b0;
            nxt_ev_trig = 1'b1;
            nxt_cnt     = {{AW{1'b0}}, 1'b1};
            if (post_n == {{AW{1'b0}}, 1'b1}) begin
              nxt_st      = ST_IDLE;
              nxt_done    = 1'b1;
              nxt_ev_done = 1'b1;
            end else begin
              nxt_st = ST_POST;
            end
          end else begin
            nxt_stg = stg_ff + 2'h1;
          end
        end
      end
      ST_POST: begin
        mem_we  = 1'b1;
        marker  = 1'b0;
        nxt_cnt = cnt_ff + 1'b1;
        if (nxt_cnt == post_n) begin
          nxt_st      = ST_IDLE;
          nxt_done    = 1'b1;
          nxt_ev_done = 1'b1;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (abort_ff) begin
      nxt_st = ST_IDLE;
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff      <= ST_IDLE;
      stg_ff     <= 2'h0;
      cnt_ff     <= {(AW+1){1'b0}};
      done_ff    <= 1'b0;
      wptr_ff    <= {AW{1'b0}};
      start_ff   <= {AW{1'b0}};
      prev_ff    <= {TRIG_W{1'b0}};
      ev_trig_ff <= 1'b0;
      ev_done_ff <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      stg_ff     <= nxt_stg;
      cnt_ff     <= nxt_cnt;
      done_ff    <= nxt_done;
      prev_ff    <= i_trigger;
      ev_trig_ff <= nxt_ev_trig;
      ev_done_ff <= nxt_ev_done;
      if (mem_we) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      // oldest kept sample sits pre_n places behind the trigger sample
      if (nxt_ev_trig) begin
        start_ff <= wptr_ff - pre_n[AW-1:0];
      end
    end
  end

  // stimulus: loaded at arm, one valid cycle per session
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_stimuli       <= {STIM_OW{1'b0}};
      o_stimuli_valid <= 1'b0;
    end else begin
      o_stimuli_valid <= arm_ff && (st_ff == ST_IDLE) && (STIM_W > 0);
      if (arm_ff && (st_ff == ST_IDLE)) begin
        o_stimuli <= stim_ff;
      end
    end
  end

  // interrupt: set beats the read-clear in the same cycle
  wire rd_istat = rd_go && (i_araddr == `ELA_OFS_ISTAT);
  wire [`ELA_INT_W-1:0] ev_vec = {ev_done_ff, ev_trig_ff};
  wire [`ELA_INT_W-1:0] nxt_istat = (istat_ff & {`ELA_INT_W{~rd_istat}}) | ev_vec;
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      istat_ff <= {`ELA_INT_W{1'b0}};
      o_irq    <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      o_irq    <= |(nxt_istat & imask_ff);
    end
  end

  // write channel capture, address and data in either order
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      o_awready  <= 1'b0;
      o_wready   <= 1'b0;
      o_bvalid   <= 1'b0;
      o_bresp    <= `ELA_RESP_OKAY;
    end else begin
      o_awready <= !aw_full_ff && !o_awready && i_awvalid;
      o_wready  <= !w_full_ff && !o_wready && i_wvalid;
      if (i_awvalid && o_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= i_wdata;
        w_strb_ff <= i_wstrb;
      end
      if (wr_go) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        o_bvalid   <= 1'b1;
        o_bresp    <= (wr_rgn == `ELA_RGN_BAD || wr_rgn == `ELA_RGN_RDAT) ?
                      `ELA_RESP_SLVERR : `ELA_RESP_OKAY;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  integer s;
  integer b;
  wire [31:0] ctrl_w = merge(32'h0, w_data_ff, w_strb_ff);
  wire [31:0] imask_w = merge({30'h0, imask_ff}, w_data_ff, w_strb_ff);
  wire [31:0] mode_w  = merge({29'h0, and_ff}, w_data_ff, w_strb_ff);
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_ff   <= 2'h0;
      ntrg_ff  <= 2'h1;
      and_ff   <= 3'h7;
      imask_ff <= {`ELA_INT_W{1'b0}};
      req_ff   <= 32'h0000_0000;
      rdidx_ff <= {AW{1'b0}};
      arm_ff   <= 1'b0;
      abort_ff <= 1'b0;
      stim_ff  <= {STIM_OW{1'b0}};
      for (s = 0; s < `ELA_NSTG; s = s + 1) begin
        care_ff[s] <= 64'h0;
        edge_ff[s] <= 64'h0;
        val_ff[s]  <= 64'h0;
      end
    end else begin
      arm_ff   <= 1'b0;
      abort_ff <= 1'b0;
      if (wr_go && wr_rgn == `ELA_RGN_REG) begin
        case (aw_addr_ff)
          `ELA_OFS_CTRL: begin
            arm_ff   <= ctrl_w[`ELA_CTRL_ARM];
            abort_ff <= ctrl_w[`ELA_CTRL_ABORT];
            // settings frozen while a capture runs
            if (st_ff == ST_IDLE && w_strb_ff[0]) begin
              pre_ff <= ctrl_w[`ELA_CTRL_PRE_HI:`ELA_CTRL_PRE_LO];
            end
            if (st_ff == ST_IDLE && w_strb_ff[1]) begin
              ntrg_ff <= ctrl_w[`ELA_CTRL_NTRG_HI:`ELA_CTRL_NTRG_LO];
            end
          end
          `ELA_OFS_IMASK: imask_ff <= imask_w[`ELA_INT_W-1:0];
          `ELA_OFS_MODE:  and_ff   <= mode_w[`ELA_NSTG-1:0];
          `ELA_OFS_REQ:   req_ff   <= merge(req_ff, w_data_ff, w_strb_ff);
          `ELA_OFS_RDIDX: rdidx_ff <= w_data_ff[AW-1:0];
          default: ;
        endcase
      end
      if (wr_go && wr_rgn == `ELA_RGN_STG) begin
        case (aw_addr_ff[4:0])
          `ELA_FLD_CARE_LO: care_ff[wr_stg][31:0]  <= merge(care_ff[wr_stg][31:0],
                                                            w_data_ff, w_strb_ff);
          `ELA_FLD_CARE_HI: care_ff[wr_stg][63:32] <= merge(care_ff[wr_stg][63:32],
                                                            w_data_ff, w_strb_ff);
          `ELA_FLD_EDGE_LO: edge_ff[wr_stg][31:0]  <= merge(edge_ff[wr_stg][31:0],
                                                            w_data_ff, w_strb_ff);
          `ELA_FLD_EDGE_HI: edge_ff[wr_stg][63:32] <= merge(edge_ff[wr_stg][63:32],
                                                            w_data_ff, w_strb_ff);
          `ELA_FLD_VAL_LO:  val_ff[wr_stg][31:0]   <= merge(val_ff[wr_stg][31:0],
                                                            w_data_ff, w_strb_ff);
          `ELA_FLD_VAL_HI:  val_ff[wr_stg][63:32]  <= merge(val_ff[wr_stg][63:32],
                                                            w_data_ff, w_strb_ff);
          default: ;
        endcase
      end
      if (wr_go && wr_rgn == `ELA_RGN_STIM) begin
        for (b = 0; b < STIM_OW; b = b + 1) begin
          if ((b / 32) == aw_addr_ff[5:2] && w_strb_ff[(b % 32) / 8]) begin
            stim_ff[b] <= w_data_ff[b % 32];
          end
        end
      end
    end
  end

  // read mux
  reg [31:0] rd_mux;
  integer r;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (rd_rgn)
      `ELA_RGN_REG: begin
        case (i_araddr)
          `ELA_OFS_CTRL:   rd_mux = {22'h0, ntrg_ff, 2'h0, pre_ff, 4'h0};
          `ELA_OFS_STATUS: rd_mux = {25'h0, warn, done_ff, 1'b0, stg_ff, st_ff};
          `ELA_OFS_ISTAT:  rd_mux = {30'h0, istat_ff};
          `ELA_OFS_IMASK:  rd_mux = {30'h0, imask_ff};
          `ELA_OFS_MODE:   rd_mux = {29'h0, and_ff};
          `ELA_OFS_DEPTH:  rd_mux = DEPTH;
          `ELA_OFS_REQ:    rd_mux = req_ff;
          `ELA_OFS_RDIDX:  rd_mux = {{(32-AW){1'b0}}, rdidx_ff};
          default:         rd_mux = 32'h0000_0000;
        endcase
      end
      `ELA_RGN_STG: begin
        case (i_araddr[4:0])
          `ELA_FLD_CARE_LO: rd_mux = care_ff[rd_stg][31:0];
          `ELA_FLD_CARE_HI: rd_mux = care_ff[rd_stg][63:32];
          `ELA_FLD_EDGE_LO: rd_mux = edge_ff[rd_stg][31:0];
          `ELA_FLD_EDGE_HI: rd_mux = edge_ff[rd_stg][63:32];
          `ELA_FLD_VAL_LO:  rd_mux = val_ff[rd_stg][31:0];
          `ELA_FLD_VAL_HI:  rd_mux = val_ff[rd_stg][63:32];
          default:          rd_mux = 32'h0000_0000;
        endcase
      end
      `ELA_RGN_RDAT: begin
        for (r = 0; r < NMW; r = r + 1) begin
          if (r == i_araddr[8:2]) rd_mux = rd_pad[32*r +: 32];
        end
      end
      `ELA_RGN_STIM: begin
        for (r = 0; r < STIM_OW; r = r + 1) begin
          if ((r / 32) == i_araddr[5:2]) rd_mux[r % 32] = stim_ff[r];
        end
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `ELA_RESP_OKAY;
    end else begin
      o_arready <= !o_arready && !o_rvalid && i_arvalid;
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_mux;
        o_rresp  <= (rd_rgn == `ELA_RGN_BAD) ? `ELA_RESP_SLVERR : `ELA_RESP_OKAY;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule // ela_core
`default_nettype wire

// file: tb/ela_core_monitor.sv
`default_nettype none
module ela_core_monitor #(
  parameter STIM_OW = 9
) (
  input wire logic               i_core_clk,
  input wire logic               i_rstn,
  input wire logic [STIM_OW-1:0] o_stimuli,
  input wire logic               o_stimuli_valid,
  input wire logic               o_irq,
  input wire logic               i_awvalid,
  input wire logic               o_awready,
  input wire logic               o_bvalid,
  input wire logic               i_bready,
  input wire logic               i_arvalid,
  input wire logic               o_arready,
  input wire logic               o_rvalid,
  input wire logic               i_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  a_stim_pulse: assert property (o_stimuli_valid |=> !o_stimuli_valid)
    else $error("stimulus valid wider than a cycle");
  a_stim_static: assert property (o_stimuli_valid |=> $stable(o_stimuli) [*3])
    else $error("stimulus word moved");
  a_aw_pulse: assert property (o_awready |=> !o_awready)
    else $error("awready held");
  a_wr_answer: assert property (i_awvalid && o_awready |-> ##[1:4] o_bvalid)
    else $error("no write response");
  a_b_release: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("bvalid kept");
  a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_r_release: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("rvalid kept");
  a_ar_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  c_stim: cover property (o_stimuli_valid);
  c_irq: cover property ($rose(o_irq));
  c_write: cover property (o_bvalid && i_bready);
endmodule // ela_core_monitor

bind ela_core ela_core_monitor #(.STIM_OW(STIM_OW)) u_monitor (
  .i_core_clk      (i_core_clk),
  .i_rstn          (i_rstn),
  .o_stimuli       (o_stimuli),
  .o_stimuli_valid (o_stimuli_valid),
  .o_irq           (o_irq),
  .i_awvalid       (i_awvalid),
  .o_awready       (o_awready),
  .o_bvalid        (o_bvalid),
  .i_bready        (i_bready),
  .i_arvalid       (i_arvalid),
  .o_arready       (o_arready),
  .o_rvalid        (o_rvalid),
  .i_rready        (i_rready)
);
`default_nettype wire

// file: tb/ela_dut_model.sv
`default_nettype none
module ela_dut_model #(
  parameter MON_W   = 38,
  parameter TRIG_W  = 8,
  parameter STIM_OW = 9
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  input  wire logic [TRIG_W-1:0]  i_trig_set,
  output logic [MON_W-1:0]        o_monitor,
  output logic [TRIG_W-1:0]       o_trigger,
  input  wire logic [STIM_OW-1:0] i_stimuli,
  input  wire logic               i_stimuli_valid,
  output logic [STIM_OW-1:0]      o_stim_seen,
  output logic [7:0]              o_stim_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_monitor <= '0;
      o_trigger <= '0;
      o_stim_seen <= '0;
      o_stim_cnt <= 8'h00;
    end else begin
      // free count: every stored sample differs from its neighbour
      o_monitor <= o_monitor + 1'b1;
      o_trigger <= i_trig_set;
      // word only looked at while qualified
      if (i_stimuli_valid) begin
        o_stim_seen <= i_stimuli;
        o_stim_cnt <= o_stim_cnt + 8'h01;
      end
    end
  end
endmodule // ela_dut_model
`default_nettype wire

// file: tb/test_embedded_logic_analyzer.sv
`include "ela_consts.vh"
`default_nettype none
module test_embedded_logic_analyzer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  localparam int MON_W  = 38;
  localparam int AW     = 4;
  localparam int TRIG_W = 8;
  localparam int STIM_W = 9;
  logic        core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, stv, irq;
  logic [1:0]  bresp, rresp, wresp;
  logic [3:0]  wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [37:0] mon;
  logic [7:0]  trg, trg_set, scnt;
  logic [8:0]  stim, sseen;
  int          failures, cmp_count, cyc;

  ela_core #(.MON_W(MON_W), .DEPTH(DEPTH), .AW(AW), .TRIG_W(TRIG_W), .STIM_W(STIM_W)) DUT (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_monitor(mon), .i_trigger(trg),
    .o_stimuli(stim), .o_stimuli_valid(stv), .o_irq(irq),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awrdy),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wrdy),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arrdy),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

  ela_dut_model #(.MON_W(MON_W), .TRIG_W(TRIG_W), .STIM_OW(STIM_W)) u_far (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_trig_set(trg_set),
    .o_monitor(mon), .o_trigger(trg), .i_stimuli(stim),
    .i_stimuli_valid(stv), .o_stim_seen(sseen), .o_stim_cnt(scnt));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awrdy) awvalid <= 1'b0;
      if (wvalid && wrdy) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arrdy) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d & m);
  endtask

  task automatic wait_done();
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(`ELA_OFS_STATUS, s, r);
      n++;
    end while (s[5] !== 1'b1 && n < 200);
    chk("done", 1, s[5]);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic sample(input int i, output logic [31:0] lo, output logic [31:0] hi);
    logic [1:0] r;
    wr(`ELA_OFS_RDIDX, i);
    rd(`ELA_RDAT_BASE, lo, r);
    rd(`ELA_RDAT_BASE + 12'h004, hi, r);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rdchk("depth", `ELA_OFS_DEPTH, 32'hFFFFFFFF, DEPTH);
    rdchk("mode", `ELA_OFS_MODE, 32'h7, 32'h7);
    wr(`ELA_OFS_REQ, 32'h40);
    rdchk("warn set", `ELA_OFS_STATUS, 32'h40, 32'h40);
    wr(`ELA_OFS_REQ, DEPTH);
    rdchk("warn clear", `ELA_OFS_STATUS, 32'h40, 32'h0);
    // only byte 1 may land, the zero in byte 0 must be ignored
    wstrb <= 4'h2;
    wr(`ELA_OFS_REQ, 32'h0000_0100);
    wstrb <= 4'hF;
    rdchk("req strobe", `ELA_OFS_REQ, 32'hFFFFFFFF, 32'h110);
    rdchk("warn strobe", `ELA_OFS_STATUS, 32'h40, 32'h40);
    wr(`ELA_RDAT_BASE, 32'h0);
    chk("trace write resp", 32'h2, wresp);
    rd(12'h100, d, r);
    chk("unmapped resp", 32'h2, r);
  endtask

  task automatic t_prestore();
    logic [31:0] lo, hi, first;
    int          pn;
    wr(`ELA_OFS_IMASK, 32'h2);
    wr(`ELA_STIM_BASE, 32'h1A5);
    for (int p = 0; p < 4; p++) begin
      pn = DEPTH / 4 * p;
      wr(`ELA_OFS_CTRL, 32'h100 | (p << 4));
      wr(`ELA_OFS_CTRL, 32'h101 | (p << 4));
      wait_done();
      chk("irq", 1, irq);
      rdchk("istat", `ELA_OFS_ISTAT, 32'h3, 32'h3);
      repeat (2) @(posedge core_clk);
      chk("irq cleared", 0, irq);
      sample(0, first, hi);
      if (p > 0) sample(pn - 1, lo, hi);
      chk("marker before", p > 0, hi[6]);
      sample(pn, lo, hi);
      chk("marker at", 0, hi[6]);
      sample(DEPTH - 1, lo, hi);
      chk("sample span", DEPTH - 1, lo - first);
      chk("marker after", 0, hi[6]);
    end
    chk("stim pulses", 4, scnt);
    chk("stim seen", 32'h1A5, sseen);
    chk("stim bus", 32'h1A5, stim);
  endtask

  task automatic t_trig();
    wr(`ELA_STG_BASE, 32'h03);
    wr(`ELA_STG_BASE + 12'h010, 32'h03);
    wr(`ELA_STG_BASE + 12'h020, 32'h0C);
    wr(`ELA_STG_BASE + 12'h030, 32'h0C);
    wr(`ELA_OFS_MODE, 32'h2);
    trg_set <= 8'h05;
    wr(`ELA_OFS_CTRL, 32'h200);
    wr(`ELA_OFS_CTRL, 32'h201);
    repeat (20) @(posedge core_clk);
    rdchk("or then and", `ELA_OFS_STATUS, 32'hF, 32'h6);
    trg_set <= 8'h0D;
    wait_done();
    // a steady high must not count as a rising edge
    wr(`ELA_STG_BASE, 32'h10);
    wr(`ELA_STG_BASE + 12'h008, 32'h10);
    wr(`ELA_STG_BASE + 12'h010, 32'h10);
    trg_set <= 8'h1D;
    wr(`ELA_OFS_CTRL, 32'h100);
    wr(`ELA_OFS_CTRL, 32'h101);
    repeat (20) @(posedge core_clk);
    rdchk("edge wait", `ELA_OFS_STATUS, 32'hF, 32'h2);
    wr(`ELA_OFS_CTRL, 32'h102);
    rdchk("abort idle", `ELA_OFS_STATUS, 32'h2F, 32'h0);
    wr(`ELA_OFS_CTRL, 32'h101);
    trg_set <= 8'h0D;
    repeat (2) @(posedge core_clk);
    trg_set <= 8'h1D;
    wait_done();
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    trg_set = 8'h00;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_prestore();
    t_trig();
    finish_test();
  end
endmodule // test_embedded_logic_analyzer
`default_nettype wire
